/* uic_irq_fifo_ctrl.sv */
// Notes on behaviour
// RULE_01: mask bit 4 enables sleep, only with enhanced functions; resets off.
// RULE_02: mask bit 5 enables the received-Xoff interrupt, enhanced only.
// RULE_03: mask bit 6 with auto RTS: interrupt on RTS low-to-high.
// RULE_04: mask bit 7 with auto CTS: interrupt on CTS low-to-high.
// RULE_05: source read gives highest pending; lower ones wait their turn.
// RULE_06: codes: line status 000110, timeout 001100, data ready 000100.
// RULE_07: tx 000010, modem 000000, Xoff 010000, flow 100000, none 000001.
// RULE_08: source bit 0 is 0 when pending, 1 when idle; resets to 1.
// RULE_09: source bits 7:6 both follow the FIFO enable.
// RULE_10: line status bits 1-4 and modem status bits 0-3 raise interrupts.
// RULE_11: receive timeout is four characters plus twelve bit times.
// RULE_12: tx ready when count drops below trigger, or reaches empty.
// RULE_13: rx data interrupt while count at or above trigger.
// RULE_14: line status read clears it; modem read clears modem and flow.
// RULE_15: holding read clears timeout; source read or tx write clears tx.
// RULE_16: Xoff clears on source read or Xon; special on next character.
// RULE_17: source bits 5:4 report Xoff/special and flow edges, enhanced only.
// RULE_18: FIFO enable bit must be set for other FIFO bits to take.
// RULE_19: FIFO reset bits reset pointers once and self-clear.
// RULE_20: FIFO bit 3 selects DMA mode for the ready pins.
// RULE_21: tx trigger 16/8/24/30, writable only with enhanced functions.
// RULE_22: rx trigger 8/16/24/30.
// RULE_23: upper mask, source and tx trigger bits need enhanced bit 4.
// RULE_24: mask bits 0-3 gate data, tx, line and modem interrupts.
// RULE_25: interrupt output high while any enabled source pends.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "uic_defines.svh"
module uic_irq_fifo_ctrl (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // channel status from the uart core
  input  wire logic [3:0]  line_status_err,
  input  wire logic [3:0]  modem_status_delta,
  input  wire logic [5:0]  rx_count,
  input  wire logic [5:0]  tx_count,
  input  wire logic        line_status_read,
  input  wire logic        modem_status_read,
  input  wire logic        receive_holding_read,
  input  wire logic        transmit_holding_write,
  input  wire logic        rx_char_stored,
  input  wire logic        xoff_match,
  input  wire logic        xon_match,
  input  wire logic        special_match,
  input  wire logic        request_to_send_n,
  input  wire logic        clear_to_send_n_pin,
  // character timing
  input  wire logic        bit_tick,
  input  wire logic [3:0]  char_bits,
  // controls and interrupt
  output logic             irq,
  output logic             sleep_enable,
  output logic             fifo_enable,
  output logic             rx_fifo_reset,
  output logic             tx_fifo_reset,
  output logic             dma_mode,
  output logic [5:0]       rx_trigger,
  output logic [5:0]       tx_trigger
);
  // bus state
  logic        rd_pend, next_rd_pend;
  logic        wr_pend, next_wr_pend;
  logic [7:0]  addr_q, next_addr_q;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic        accept;
  // registers
  logic [7:0]  mask_q, next_mask_q;
  logic [7:0]  efr_q, next_efr_q;
  logic        next_fifo_enable, next_rx_fifo_reset, next_tx_fifo_reset;
  logic        next_dma_mode, next_sleep_enable, next_irq;
  logic [5:0]  next_rx_trigger, next_tx_trigger;
  // interrupt flags
  logic        tmo_q, next_tmo_q;
  logic        txr_q, next_txr_q;
  logic        xsc_q, next_xsc_q;
  logic        spc_q, next_spc_q;
  logic        flow_q, next_flow_q;
  logic        tx_below_q, tx_empty_q, rts_q, cts_q;
  logic        cts_meta, cts_sync;
  logic        tmo_exp, tx_below, tx_empty, rx_hit;
  logic        txr_set, xsc_set, flow_set, src_read;
  logic        enh, rts_rise, cts_rise;
  logic [7:0]  src_val;
  uic_pkg::uic_src_t src;

  function automatic logic [5:0] tx_trig_f(input logic [1:0] s);
    case (s)
      2'h0:    tx_trig_f = `UIC_TX_TRIG0;
      2'h1:    tx_trig_f = `UIC_TX_TRIG1;
      2'h2:    tx_trig_f = `UIC_TX_TRIG2;
      default: tx_trig_f = `UIC_TX_TRIG3;
    endcase
  endfunction

  function automatic logic [5:0] rx_trig_f(input logic [1:0] s);
    case (s)
      2'h0:    rx_trig_f = `UIC_RX_TRIG0;
      2'h1:    rx_trig_f = `UIC_RX_TRIG1;
      2'h2:    rx_trig_f = `UIC_RX_TRIG2;
      default: rx_trig_f = `UIC_RX_TRIG3;
    endcase
  endfunction

  function automatic logic [5:0] code_f(input uic_pkg::uic_src_t s);
    case (s)
      uic_pkg::UIC_SRC_LSR:  code_f = `UIC_CODE_LSR;
      uic_pkg::UIC_SRC_TMO:  code_f = `UIC_CODE_TMO;
      uic_pkg::UIC_SRC_RXD:  code_f = `UIC_CODE_RXD;
      uic_pkg::UIC_SRC_TXR:  code_f = `UIC_CODE_TXR;
      uic_pkg::UIC_SRC_MSR:  code_f = `UIC_CODE_MSR;
      uic_pkg::UIC_SRC_XSC:  code_f = `UIC_CODE_XSC;
      uic_pkg::UIC_SRC_FLOW: code_f = `UIC_CODE_FLOW;
      default:               code_f = `UIC_CODE_NONE;
    endcase
  endfunction

  uic_rx_timeout u_tmo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .bit_tick  (bit_tick),
    .char_bits (char_bits),
    .run       (fifo_enable && rx_count != 6'h00),
    .restart   (rx_char_stored || receive_holding_read),
    .expire    (tmo_exp)
  );

  assign enh = efr_q[`UIC_EB_ENH];
  // RULE_03: rts rising while auto rts is on
  assign rts_rise = request_to_send_n && !rts_q && efr_q[`UIC_EB_ARTS]
                    && mask_q[`UIC_MB_RTS];
  // RULE_04: cts rising while auto cts is on
  assign cts_rise = cts_sync && !cts_q && efr_q[`UIC_EB_ACTS]
                    && mask_q[`UIC_MB_CTS];

  // RULE_13: data ready tracks the trigger, falls as the host drains
  assign rx_hit   = fifo_enable ? (rx_count >= rx_trigger)
                                : (rx_count != 6'h00);
  // RULE_12: below-trigger and empty edges both arm tx ready
  assign tx_below = fifo_enable ? (tx_count < tx_trigger)
                                : (tx_count == 6'h00);
  assign tx_empty = tx_count == 6'h00;
  // mask arming is decoded from the write itself so no loop runs through
  // the register process that also consumes this set term
  assign txr_set  = (tx_below && !tx_below_q) || (tx_empty && !tx_empty_q)
                    || (wr_pend && addr_q == `UIC_OFS_MASK
                        && hwdata[`UIC_MB_TXR] && !mask_q[`UIC_MB_TXR]
                        && tx_below);
  assign xsc_set  = enh && (xoff_match || special_match);
  assign flow_set = enh && (rts_rise || cts_rise);

  // RULE_05: fixed priority; only the top source is reported at a time
  always_comb begin
    src = uic_pkg::UIC_SRC_NONE;
    // RULE_24: low mask bits gate the classic sources
    // RULE_10: line and modem status bits raise their sources
    // RULE_17: upper sources only with enhanced functions
    if (mask_q[`UIC_MB_LSR] && |line_status_err)
      src = uic_pkg::UIC_SRC_LSR;
    else if (mask_q[`UIC_MB_RXD] && tmo_q)
      src = uic_pkg::UIC_SRC_TMO;
    else if (mask_q[`UIC_MB_RXD] && rx_hit)
      src = uic_pkg::UIC_SRC_RXD;
    else if (mask_q[`UIC_MB_TXR] && txr_q)
      src = uic_pkg::UIC_SRC_TXR;
    else if (mask_q[`UIC_MB_MSR] && |modem_status_delta)
      src = uic_pkg::UIC_SRC_MSR;
    else if (enh && mask_q[`UIC_MB_XOFF] && xsc_q)
      src = uic_pkg::UIC_SRC_XSC;
    else if (enh && flow_q)
      src = uic_pkg::UIC_SRC_FLOW;
  end

  // RULE_06: receive codes in bits 5..0
  // RULE_07: remaining codes and idle code
  // RULE_09: bits 7:6 mirror the fifo enable
  assign src_val  = {fifo_enable, fifo_enable, code_f(src)};
  assign accept   = hsel && hready && htrans[1];
  assign src_read = rd_pend && addr_q == `UIC_OFS_SOURCE;

  // bus: reads take one wait state so hrdata leaves a flop
  always_comb begin
    next_rd_pend   = 1'b0;
    next_wr_pend   = 1'b0;
    next_addr_q    = addr_q;
    next_hrdata    = hrdata;
    next_hreadyout = 1'b1;
    if (accept) begin
      next_addr_q    = haddr[7:0];
      next_rd_pend   = !hwrite && haddr[31:8] == 24'h000000;
      next_wr_pend   = hwrite && haddr[31:8] == 24'h000000;
      next_hreadyout = hwrite;
      next_hrdata    = 32'h00000000;
    end
    if (rd_pend) begin
      case (addr_q)
        `UIC_OFS_MASK:   next_hrdata = {24'h000000, mask_q};
        // RULE_08: bit 0 high only when nothing pends
        `UIC_OFS_SOURCE: next_hrdata = {24'h000000, src_val};
        `UIC_OFS_ENH:    next_hrdata = {24'h000000, efr_q};
        default:         next_hrdata = 32'h00000000;
      endcase
    end
  end

  // registers and flags
  always_comb begin
    next_mask_q        = mask_q;
    next_efr_q         = efr_q;
    next_fifo_enable   = fifo_enable;
    next_rx_fifo_reset = 1'b0;
    next_tx_fifo_reset = 1'b0;
    next_dma_mode      = dma_mode;
    next_rx_trigger    = rx_trigger;
    next_tx_trigger    = tx_trigger;
    if (wr_pend) begin
      case (addr_q)
        `UIC_OFS_MASK: begin
          next_mask_q[3:0] = hwdata[3:0];
          // RULE_23: upper mask bits locked unless enhanced
          if (enh)
            next_mask_q[7:4] = hwdata[7:4];
        end
        `UIC_OFS_ENH: next_efr_q = hwdata[7:0];
        `UIC_OFS_FIFO: begin
          // RULE_18: other bits only take with the enable set
          next_fifo_enable = hwdata[`UIC_FB_EN];
          if (hwdata[`UIC_FB_EN]) begin
            // RULE_19: one-cycle pointer resets, shifters untouched
            next_rx_fifo_reset = hwdata[`UIC_FB_RXRST];
            next_tx_fifo_reset = hwdata[`UIC_FB_TXRST];
            // RULE_20: dma mode select
            next_dma_mode      = hwdata[`UIC_FB_DMA];
            // RULE_22: receive trigger
            next_rx_trigger    = rx_trig_f(hwdata[7:6]);
            // RULE_21: transmit trigger needs enhanced functions
            if (enh)
              next_tx_trigger = tx_trig_f(hwdata[5:4]);
          end
        end
        default: next_mask_q = mask_q;
      endcase
    end
    // RULE_01: sleep only counts with enhanced functions
    next_sleep_enable = next_mask_q[`UIC_MB_SLEEP] && next_efr_q[`UIC_EB_ENH];
    // RULE_25: output follows any enabled pending source
    next_irq = src != uic_pkg::UIC_SRC_NONE;
    // a set in the same cycle as its clear always wins
    // RULE_15: timeout clears on holding read
    next_tmo_q = tmo_exp || (tmo_q && !receive_holding_read);
    // RULE_15: tx ready clears on source read or tx write
    next_txr_q = txr_set || (txr_q && !transmit_holding_write
                 && !(src_read && src == uic_pkg::UIC_SRC_TXR));
    // RULE_16: xoff clears on xon, special on the next character
    next_xsc_q = xsc_set || (xsc_q
                 && !(src_read && src == uic_pkg::UIC_SRC_XSC)
                 && !(xon_match && !spc_q)
                 && !(rx_char_stored && spc_q));
    next_spc_q = xsc_set ? (special_match && !xoff_match) : spc_q;
    // RULE_02: xoff interrupt needs mask bit 5, applied in the encoder
    // RULE_14: flow edges clear on modem status read
    next_flow_q = flow_set || (flow_q && !modem_status_read);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend   <= 1'b0;
      wr_pend   <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      rd_pend   <= next_rd_pend;
      wr_pend   <= next_wr_pend;
      addr_q    <= next_addr_q;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q        <= `UIC_RST_MASK;
      efr_q         <= `UIC_RST_ENH;
      fifo_enable   <= 1'b0;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      dma_mode      <= 1'b0;
      rx_trigger    <= `UIC_RST_RXTRIG;
      tx_trigger    <= `UIC_RST_TXTRIG;
      sleep_enable  <= 1'b0;
      irq           <= 1'b0;
      tmo_q         <= 1'b0;
      txr_q         <= 1'b0;
      xsc_q         <= 1'b0;
      spc_q         <= 1'b0;
      flow_q        <= 1'b0;
      tx_below_q    <= 1'b1;
      tx_empty_q    <= 1'b1;
      rts_q         <= 1'b1;
      cts_q         <= 1'b1;
      cts_meta      <= 1'b1;
      cts_sync      <= 1'b1;
    end else begin
      mask_q        <= next_mask_q;
      efr_q         <= next_efr_q;
      fifo_enable   <= next_fifo_enable;
      rx_fifo_reset <= next_rx_fifo_reset;
      tx_fifo_reset <= next_tx_fifo_reset;
      dma_mode      <= next_dma_mode;
      rx_trigger    <= next_rx_trigger;
      tx_trigger    <= next_tx_trigger;
      sleep_enable  <= next_sleep_enable;
      irq           <= next_irq;
      tmo_q         <= next_tmo_q;
      txr_q         <= next_txr_q;
      xsc_q         <= next_xsc_q;
      spc_q         <= next_spc_q;
      flow_q        <= next_flow_q;
      tx_below_q    <= tx_below;
      tx_empty_q    <= tx_empty;
      rts_q         <= request_to_send_n;
      cts_q         <= cts_sync;
      // pin crosses two flops before any edge logic sees it
      cts_meta      <= clear_to_send_n_pin;
      cts_sync      <= cts_meta;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_sleep_gate: assert property ( // RULE_01
    sleep_enable |-> $past(next_mask_q[4] && next_efr_q[4]))
    else $error("sleep enabled without enhanced functions");
  a_mask_lock: assert property ( // RULE_23
    wr_pend && addr_q == `UIC_OFS_MASK && !enh
    |=> mask_q[7:4] == $past(mask_q[7:4]))
    else $error("upper mask bits changed while locked");
  a_idle_bit: assert property ( // RULE_08
    src_read |=> hrdata[0] == ($past(src) == uic_pkg::UIC_SRC_NONE))
    else $error("source idle bit wrong");
  a_fifo_bits: assert property ( // RULE_09
    src_read |=> hrdata[7:6] == {2{$past(fifo_enable)}})
    else $error("source fifo bits do not follow enable");
  a_fcr_ignore: assert property ( // RULE_18
    wr_pend && addr_q == `UIC_OFS_FIFO && !hwdata[0]
    |=> !fifo_enable && !rx_fifo_reset && tx_trigger == $past(tx_trigger))
    else $error("fifo bits programmed without enable");
  a_reset_pulse: assert property ( // RULE_19
    rx_fifo_reset || tx_fifo_reset |=> !rx_fifo_reset && !tx_fifo_reset)
    else $error("fifo reset did not self-clear");
  a_flow_clear: assert property ( // RULE_14
    modem_status_read && !flow_set |=> !flow_q)
    else $error("flow interrupt survived modem read");
  a_tmo_clear: assert property ( // RULE_15
    receive_holding_read && !tmo_exp |=> !tmo_q)
    else $error("timeout survived holding read");
  a_cts_edge: assert property ( // RULE_04
    enh && cts_rise |=> flow_q ##1 $past(flow_q))
    else $error("cts rising edge not flagged");
  a_irq_follow: assert property ( // RULE_25
    src != uic_pkg::UIC_SRC_NONE |=> irq)
    else $error("interrupt output missed a pending source");

endmodule // uic_irq_fifo_ctrl

/* uic_defines.svh */
`ifndef UIC_DEFINES_SVH
`define UIC_DEFINES_SVH

// register byte offsets
`define UIC_OFS_MASK     8'h00
`define UIC_OFS_SOURCE   8'h04
`define UIC_OFS_FIFO     8'h08
`define UIC_OFS_ENH      8'h0c

// reset values
`define UIC_RST_MASK     8'h00
`define UIC_RST_ENH      8'h00
`define UIC_RST_RXTRIG   6'h08
`define UIC_RST_TXTRIG   6'h10

// interrupt_mask bits
`define UIC_MB_RXD       0
`define UIC_MB_TXR       1
`define UIC_MB_LSR       2
`define UIC_MB_MSR       3
`define UIC_MB_SLEEP     4
`define UIC_MB_XOFF      5
`define UIC_MB_RTS       6
`define UIC_MB_CTS       7

// enhanced_feature bits
`define UIC_EB_ENH       4
`define UIC_EB_ARTS      6
`define UIC_EB_ACTS      7

// fifo_control bits
`define UIC_FB_EN        0
`define UIC_FB_RXRST     1
`define UIC_FB_TXRST     2
`define UIC_FB_DMA       3

// interrupt_source codes, bits 5..0
`define UIC_CODE_LSR     6'h06
`define UIC_CODE_TMO     6'h0c
`define UIC_CODE_RXD     6'h04
`define UIC_CODE_TXR     6'h02
`define UIC_CODE_MSR     6'h00
`define UIC_CODE_XSC     6'h10
`define UIC_CODE_FLOW    6'h20
`define UIC_CODE_NONE    6'h01

// trigger levels
`define UIC_TX_TRIG0     6'h10
`define UIC_TX_TRIG1     6'h08
`define UIC_TX_TRIG2     6'h18
`define UIC_TX_TRIG3     6'h1e
`define UIC_RX_TRIG0     6'h08
`define UIC_RX_TRIG1     6'h10
`define UIC_RX_TRIG2     6'h18
`define UIC_RX_TRIG3     6'h1e

// receive timeout: characters plus bit times
`define UIC_TMO_CHARS    7'h04
`define UIC_TMO_BITS     7'h0c

`endif

/* uic_pkg.sv */
package uic_pkg;
  typedef enum logic [2:0] {
    UIC_SRC_NONE,
    UIC_SRC_LSR,
    UIC_SRC_TMO,
    UIC_SRC_RXD,
    UIC_SRC_TXR,
    UIC_SRC_MSR,
    UIC_SRC_XSC,
    UIC_SRC_FLOW
  } uic_src_t;
endpackage

/* uic_rx_timeout.sv */
`timescale 1ns/10ps
`include "uic_defines.svh"
module uic_rx_timeout (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // timing
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  // receive activity
  input  wire logic       run,
  input  wire logic       restart,
  // result
  output logic            expire
);
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       next_expire;
  logic [6:0] limit;

  // RULE_11: four characters plus twelve bits
  assign limit = 7'(`UIC_TMO_CHARS * {3'h0, char_bits}) + `UIC_TMO_BITS;

  always_comb begin
    next_cnt    = cnt;
    next_expire = 1'b0;
    if (restart || !run) begin
      next_cnt = 7'h00;
    end else if (bit_tick && cnt != limit) begin
      next_cnt = cnt + 7'h01;
      // one pulse only; timer then parks until restarted
      next_expire = (cnt + 7'h01) == limit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt    <= 7'h00;
      expire <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      expire <= next_expire;
    end
  end

  a_tmo_limit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    expire |-> $past(cnt) == limit - 7'h01 && cnt == limit)
    else $error("receive timeout fired before the full delay");

endmodule // uic_rx_timeout

/* uic_core_model.sv */
`timescale 1ns/10ps
module uic_core_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // status events from the bench
  input  wire logic [3:0] set_lsr,
  input  wire logic [3:0] set_msr,
  input  wire logic       line_status_read,
  input  wire logic       modem_status_read,
  // status towards the block
  output logic [3:0]      line_status_err,
  output logic [3:0]      modem_status_delta,
  output logic            bit_tick
);
  logic [1:0] div;
  // a new event on the read edge survives, as in the real status latch
  // status set, read clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div                <= 2'h0;
      bit_tick           <= 1'b0;
      line_status_err    <= 4'h0;
      modem_status_delta <= 4'h0;
    end else begin
      div                <= div + 2'h1;
      bit_tick           <= (div == 2'h3);
      line_status_err    <= line_status_read ? set_lsr :
                            (line_status_err | set_lsr);
      modem_status_delta <= modem_status_read ? set_msr :
                            (modem_status_delta | set_msr);
    end
  end
endmodule // uic_core_model

/* uic_irq_fifo_ctrl_tb.sv */
`timescale 1ns/10ps
`include "uic_defines.svh"
module uic_irq_fifo_ctrl_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  set_lsr, set_msr, lse, msd, char_bits;
  logic [5:0]  rx_count, tx_count, rx_trigger, tx_trigger;
  logic [7:0]  ev;
  logic        rts_n, cts_n, bit_tick, sleep_enable, fifo_enable, dma_mode;
  logic        rx_fifo_reset, tx_fifo_reset;
  int          num_errors, comparisons, nrx, ntx;
  logic [5:0]  txt [4] = '{6'h10, 6'h08, 6'h18, 6'h1e};
  logic [5:0]  rxt [4] = '{6'h08, 6'h10, 6'h18, 6'h1e};

  uic_core_model i_core (.hclk(hclk), .hresetn(hresetn), .set_lsr(set_lsr),
    .set_msr(set_msr), .line_status_read(ev[0]),
    .modem_status_read(ev[1]), .line_status_err(lse),
    .modem_status_delta(msd), .bit_tick(bit_tick));

  uic_irq_fifo_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .line_status_err(lse),
    .modem_status_delta(msd), .rx_count(rx_count), .tx_count(tx_count),
    .line_status_read(ev[0]), .modem_status_read(ev[1]),
    .receive_holding_read(ev[2]), .transmit_holding_write(ev[3]),
    .rx_char_stored(ev[4]), .xoff_match(ev[5]), .xon_match(ev[6]),
    .special_match(ev[7]), .request_to_send_n(rts_n),
    .clear_to_send_n_pin(cts_n), .bit_tick(bit_tick),
    .char_bits(char_bits), .irq(irq), .sleep_enable(sleep_enable),
    .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
    .tx_fifo_reset(tx_fifo_reset), .dma_mode(dma_mode),
    .rx_trigger(rx_trigger), .tx_trigger(tx_trigger));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (rx_fifo_reset === 1'b1) nrx++;
    if (tx_fifo_reset === 1'b1) ntx++;
  end

  task results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  // ready is stable from the negedge to the sampling edge
  task wait_rdy();
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
    rd_q = hrdata;
    @(posedge hclk);
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    chk(hresp, 32'h0, "okay response");
    rdat = rd_q;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, {24'h0, e}, w);
  endtask

  task pulse(input int b);
    @(posedge hclk);
    ev[b] <= 1'b1;
    @(posedge hclk);
    ev[b] <= 1'b0;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task t_reset();
    rdchk(`UIC_OFS_MASK, 8'h00, "mask reset");
    rdchk(`UIC_OFS_SOURCE, 8'h01, "source reset");
    rdchk(`UIC_OFS_FIFO, 8'h00, "fifo reads zero");
    rdchk(8'h40, 8'h00, "unmapped");
    chk(rx_trigger, 6'h08, "rx trigger reset");
    chk(tx_trigger, 6'h10, "tx trigger reset");
    chk(fifo_enable, 1'b0, "fifo off");
    chk(sleep_enable, 1'b0, "sleep off");
    chk(irq, 1'b0, "irq idle");
    $display("test reset done");
  endtask

  task t_fifo();
    wr(`UIC_OFS_FIFO, 8'hc8);
    cyc(2);
    chk(dma_mode, 1'b0, "ignored without enable");
    chk(rx_trigger, 6'h08, "ignored trigger");
    wr(`UIC_OFS_FIFO, 8'hd9);
    cyc(2);
    chk(fifo_enable, 1'b1, "fifo on");
    chk(dma_mode, 1'b1, "dma on");
    chk(rx_trigger, 6'h1e, "rx trigger 30");
    chk(tx_trigger, 6'h10, "tx trigger locked");
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "fifo status on");
    wr(`UIC_OFS_FIFO, 8'h07);
    cyc(2);
    chk(nrx, 1, "rx reset pulse");
    chk(ntx, 1, "tx reset pulse");
    wr(`UIC_OFS_FIFO, 8'h06);
    cyc(2);
    chk(nrx, 1, "reset needs enable");
    chk(fifo_enable, 1'b0, "fifo off again");
    rdchk(`UIC_OFS_SOURCE, 8'h01, "fifo status off");
    wr(`UIC_OFS_FIFO, 8'h01);
    $display("test fifo done");
  endtask

  task t_prio();
    @(posedge hclk);
    tx_count <= 6'h00;
    rx_count <= 6'h08;
    wr(`UIC_OFS_MASK, 8'h0f);
    @(posedge hclk);
    set_lsr <= 4'h2;
    set_msr <= 4'h1;
    @(posedge hclk);
    set_lsr <= 4'h0;
    set_msr <= 4'h0;
    cyc(3);
    chk(irq, 1'b1, "irq pending");
    rdchk(`UIC_OFS_SOURCE, 8'hc6, "line status first");
    pulse(0);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc4, "rx data next");
    @(posedge hclk);
    rx_count <= 6'h07;
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc2, "tx ready next");
    rdchk(`UIC_OFS_SOURCE, 8'hc0, "modem last");
    pulse(1);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "all clear");
    chk(irq, 1'b0, "irq released");
    @(posedge hclk);
    rx_count <= 6'h00;
    tx_count <= 6'h14;
    wr(`UIC_OFS_MASK, 8'h02);
    @(posedge hclk);
    tx_count <= 6'h0a;
    cyc(3);
    chk(irq, 1'b1, "tx below trigger");
    pulse(3);
    cyc(3);
    chk(irq, 1'b0, "tx write clears");
    @(posedge hclk);
    tx_count <= 6'h00;
    cyc(3);
    chk(irq, 1'b1, "tx empty");
    pulse(3);
    wr(`UIC_OFS_MASK, 8'h00);
    @(posedge hclk);
    set_lsr <= 4'h8;
    @(posedge hclk);
    set_lsr <= 4'h0;
    cyc(3);
    chk(irq, 1'b0, "masked line status");
    pulse(0);
    $display("test priority done");
  endtask

  task t_tmo();
    @(posedge hclk);
    rx_count <= 6'h01;
    wr(`UIC_OFS_MASK, 8'h01);
    pulse(4);
    cyc(150);
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "timer running");
    cyc(80);
    rdchk(`UIC_OFS_SOURCE, 8'hcc, "timeout");
    @(posedge hclk);
    rx_count <= 6'h00;
    pulse(2);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "holding read clears");
    $display("test timeout done");
  endtask

  task t_enh();
    wr(`UIC_OFS_MASK, 8'h10);
    cyc(2);
    chk(sleep_enable, 1'b0, "sleep needs enh");
    wr(`UIC_OFS_ENH, 8'hd0);
    wr(`UIC_OFS_MASK, 8'hf0);
    cyc(2);
    chk(sleep_enable, 1'b1, "sleep on");
    rdchk(`UIC_OFS_MASK, 8'hf0, "upper mask");
    for (int i = 0; i < 4; i++) begin
      wr(`UIC_OFS_FIFO, {i[1:0], i[1:0], 4'h1});
      cyc(2);
      chk(tx_trigger, txt[i], "tx trigger");
      chk(rx_trigger, rxt[i], "rx trigger");
    end
    wr(`UIC_OFS_FIFO, 8'h01);
    @(posedge hclk);
    cts_n <= 1'b1;
    cyc(6);
    chk(irq, 1'b1, "cts edge irq");
    rdchk(`UIC_OFS_SOURCE, 8'he0, "cts edge");
    pulse(1);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "modem read clears");
    @(posedge hclk);
    rts_n <= 1'b1;
    cyc(4);
    rdchk(`UIC_OFS_SOURCE, 8'he0, "rts edge");
    pulse(1);
    pulse(5);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hd0, "xoff");
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "source read clears");
    pulse(5);
    pulse(6);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "xon clears");
    pulse(7);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hd0, "special");
    pulse(7);
    cyc(3);
    chk(irq, 1'b1, "special pending");
    pulse(4);
    cyc(3);
    rdchk(`UIC_OFS_SOURCE, 8'hc1, "next char clears");
    wr(`UIC_OFS_ENH, 8'h00);
    cyc(2);
    chk(sleep_enable, 1'b0, "sleep off with enh");
    $display("test enhanced done");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    set_lsr = 4'h0;
    set_msr = 4'h0;
    rx_count = 6'h00;
    tx_count = 6'h14;
    ev = 8'h00;
    rts_n = 1'b0;
    cts_n = 1'b0;
    char_bits = 4'ha;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_fifo();
    t_prio();
    t_tmo();
    t_enh();
    results();
  end

  // the whole run needs about 500 cycles
  initial begin
    #(20000 * 100);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end
endmodule // uic_irq_fifo_ctrl_tb
